// >>> isp_consts.svh
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH

// Instruction first bytes and fields
`define ISP_PROG_EN       8'hac
`define ISP_ECHO_BYTE     8'h53
`define ISP_ERASE_SEL     3'b100
`define ISP_LOAD_PAGE     8'h40
`define ISP_H_MASK        8'hf7
`define ISP_H_BIT         3
`define ISP_WRITE_PAGE    8'h4c
`define ISP_READ_PROG     8'h20
`define ISP_READ_EE       8'ha0
`define ISP_WRITE_EE      8'hc0

// Erased content
`define ISP_ERASED_BYTE   8'hff
`define ISP_ERASED_WORD   16'hffff

// Frame framing: 32 bits, read data goes out in the fourth byte
`define ISP_LAST_BIT      5'h1f
`define ISP_READ_BIT      5'h18
`define ISP_BYTE_END      3'h7
`define ISP_BYTE_START    3'h0

// Page buffer
`define ISP_PAGE_WORDS    128
`define ISP_LAST_WORD     7'h7f

// Power-on sampling point of the entry pin, after its synchroniser
`define ISP_POR_SAMPLE    2'h3

// Timing: clock rate and minimum waits in microseconds
`define ISP_CLK_MHZ       125
`define ISP_FLASH_WAIT_US 4500
`define ISP_EE_WAIT_US    9000
`define ISP_FLASH_WAIT_CYC (`ISP_FLASH_WAIT_US * `ISP_CLK_MHZ)
`define ISP_EE_WAIT_CYC   (`ISP_EE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_WAIT_W        21

`endif

// >>> isp_pkg.sv
package isp_pkg;

  // Write engine states, Gray along idle -> stream -> wait
  typedef enum logic [1:0] {
    PG_IDLE   = 2'b00,
    PG_STREAM = 2'b01,
    PG_WAIT   = 2'b11
  } prog_state_t;

  // Operation requested from the nonvolatile array
  typedef enum logic [2:0] {
    MEM_NONE     = 3'h0,
    MEM_RD_FLASH = 3'h1,
    MEM_RD_EE    = 3'h2,
    MEM_WR_FLASH = 3'h3,
    MEM_WR_EE    = 3'h4,
    MEM_ERASE    = 3'h5
  } mem_cmd_t;

  // What the running self-timed write is, for read-back masking
  typedef enum logic [1:0] {
    BUSY_FLASH = 2'h0,
    BUSY_EE    = 2'h1,
    BUSY_ERASE = 2'h2
  } busy_kind_t;

endpackage

// >>> ser_if.sv
interface ser_if;
  logic        sck;
  logic        sdi;
  logic        clear;
  logic [7:0]  reply;
  logic [31:0] rx_word;
  logic [4:0]  bit_cnt;
  logic        byte_tick;
  logic        frame_tick;
  logic        sdo;

  modport engine (input sck, sdi, clear, reply,
                  output rx_word, bit_cnt, byte_tick, frame_tick, sdo);
  modport core   (output sck, sdi, clear, reply,
                  input rx_word, bit_cnt, byte_tick, frame_tick, sdo);
endinterface

// >>> sync2.sv
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,   // Core clock
  input  wire logic         rst_n, // Synchronised reset
  input  wire logic [W-1:0] d,     // Asynchronous inputs
  output logic      [W-1:0] q      // Synchronised outputs
);
  logic [W-1:0] meta_reg;

  // Two stages; the first is read by the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // sync2

// >>> ser_shift.sv
`include "isp_consts.svh"

module ser_shift (
  input  wire logic clk,   // Core clock
  input  wire logic rst_n, // Synchronised reset
  ser_if.engine     sif    // Link side towards the core
);
  logic        sck_q_reg, sck_q_next;
  logic [31:0] rx_reg, rx_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [7:0]  tx_reg, tx_next;
  logic        sdo_reg, sdo_next;
  logic        btick_reg, btick_next;
  logic        ftick_reg, ftick_next;
  logic        rise, fall;

  // Edge finding on the already synchronised serial clock
  assign rise = sif.sck & ~sck_q_reg;
  assign fall = ~sif.sck & sck_q_reg;

  always_comb begin
    sck_q_next = sif.sck;
    rx_next    = rx_reg;
    cnt_next   = cnt_reg;
    tx_next    = tx_reg;
    sdo_next   = sdo_reg;
    btick_next = 1'b0;
    ftick_next = 1'b0;
    if (sif.clear) begin
      cnt_next = 5'h00;
      tx_next  = 8'h00;
      sdo_next = 1'b0;
    end else if (rise) begin
      rx_next    = {rx_reg[30:0], sif.sdi};
      cnt_next   = cnt_reg + 5'h01;
      btick_next = (cnt_reg[2:0] == `ISP_BYTE_END);
      ftick_next = (cnt_reg == `ISP_LAST_BIT);
    end else if (fall) begin
      if (cnt_reg[2:0] == `ISP_BYTE_START) begin
        sdo_next = sif.reply[7];
        tx_next  = {sif.reply[6:0], 1'b0};
      end else begin
        sdo_next = tx_reg[7];
        tx_next  = {tx_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q_reg <= 1'b0;
      rx_reg    <= 32'h00000000;
      cnt_reg   <= 5'h00;
      tx_reg    <= 8'h00;
      sdo_reg   <= 1'b0;
      btick_reg <= 1'b0;
      ftick_reg <= 1'b0;
    end else begin
      sck_q_reg <= sck_q_next;
      rx_reg    <= rx_next;
      cnt_reg   <= cnt_next;
      tx_reg    <= tx_next;
      sdo_reg   <= sdo_next;
      btick_reg <= btick_next;
      ftick_reg <= ftick_next;
    end
  end

  assign sif.rx_word    = rx_reg;
  assign sif.bit_cnt    = cnt_reg;
  assign sif.byte_tick  = btick_reg;
  assign sif.frame_tick = ftick_reg;
  assign sif.sdo        = sdo_reg;
endmodule // ser_shift

// >>> isp_port.sv
// Summary of operation
// - Flash and EEPROM are writable over the link while reset is low.
// - Program and erase are refused until programming enable executes.
// - Serial input is sampled on the rising serial clock edge.
// - Serial output changes on the falling serial clock edge.
// - Entry pin held low at power-on enters mode; sampled only then.
// - Pin entry holds the mode until power goes away.
// - Second byte 0x53 echoes while the third enable byte shifts in.
// - Load-page places one byte in the buffer at a 7-bit word index.
// - Write-page commits the buffer to the page picked by 8 bits.
// - EEPROM byte writes self-time and erase the location first.
// - Chip erase sets all flash and EEPROM locations to 0xFF.
// - Read returns the addressed content on serial output.
// - Reset high ends a session entered by reset low; normal operation begins.
// - Reading the page being written returns 0xFF until done.
// - Enable is 0xAC, 0x53, then two don't care bytes.
// - Load-page starts 0100 H000; write-page starts 0100 1100.
// - Read-program starts 0010 H000; byte returned in fourth byte.
`include "isp_consts.svh"

module isp_port #(
  parameter int unsigned FLASH_WAIT_CYC = `ISP_FLASH_WAIT_CYC,
  parameter int unsigned EE_WAIT_CYC    = `ISP_EE_WAIT_CYC
) (
  input  wire logic              clk,              // Core clock, 125 MHz
  input  wire logic              rstn,             // Power-on reset, low
  input  wire logic              reset_pin_n,      // Device reset pin
  input  wire logic              prog_entry_pin_n, // Entry pin, low = enter
  input  wire logic              sck,              // Serial clock pin
  input  wire logic              sdi,              // Serial data in pin
  output logic                   sdo,              // Serial data out pin
  output logic                   hold_cpu,         // Session active
  output logic                   busy,             // Self-timed write runs
  output logic                   mem_req,          // Array request pulse
  output isp_pkg::mem_cmd_t      mem_cmd,          // Array operation
  output logic            [14:0] mem_addr,         // Word or byte address
  output logic            [15:0] mem_wdata,        // Write data
  input  wire logic       [15:0] mem_rdata         // Read data, next cycle
);
  logic        rst_meta_reg, rst_n_s;
  logic [3:0]  pins_s;
  logic        rpin_s, pen_s;
  logic        session;
  ser_if       sif ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n_s      <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_s      <= rst_meta_reg;
    end
  end

  sync2 #(.W(4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n_s),
    .d     ({reset_pin_n, prog_entry_pin_n, sck, sdi}),
    .q     (pins_s)
  );

  assign rpin_s  = pins_s[3];
  assign pen_s   = pins_s[2];
  assign sif.sck = pins_s[1];
  assign sif.sdi = pins_s[0];

  ser_shift u_shift (
    .clk   (clk),
    .rst_n (rst_n_s),
    .sif   (sif)
  );

  // Power-on capture of the entry pin
  logic [1:0] por_cnt_reg, por_cnt_next;
  logic       pen_lat_reg, pen_lat_next;

  always_comb begin
    por_cnt_next = por_cnt_reg;
    pen_lat_next = pen_lat_reg;
    if (por_cnt_reg != `ISP_POR_SAMPLE) begin
      por_cnt_next = por_cnt_reg + 2'h1;
    end
    if (por_cnt_reg == (`ISP_POR_SAMPLE - 2'h1)) begin
      pen_lat_next = ~pen_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      por_cnt_reg <= 2'h0;
      pen_lat_reg <= 1'b0;
    end else begin
      por_cnt_reg <= por_cnt_next;
      pen_lat_reg <= pen_lat_next;
    end
  end

  assign session   = pen_lat_reg | (~rpin_s & (por_cnt_reg == `ISP_POR_SAMPLE));
  assign sif.clear = ~session;

  // Instruction bytes of a finished frame, and of a frame in progress
  logic [7:0]  b1, b2, b3, b4;
  logic [7:0]  p1, p2, p3;
  assign {b1, b2, b3, b4} = sif.rx_word;
  assign {p1, p2, p3}     = sif.rx_word[23:0];

  // Core state
  isp_pkg::prog_state_t   st_reg, st_next;
  isp_pkg::busy_kind_t    kind_reg, kind_next;
  logic                   en_reg, en_next;
  logic [`ISP_WAIT_W-1:0] wait_reg, wait_next;
  logic [6:0]             idx_reg, idx_next;
  logic [7:0]             page_reg, page_next;
  logic [10:0]            ee_addr_reg, ee_addr_next;
  logic [15:0]            buf_reg [`ISP_PAGE_WORDS];
  logic [15:0]            buf_next [`ISP_PAGE_WORDS];
  logic                   rd_pend_reg, rd_pend_next;
  logic                   rd_flash_reg, rd_flash_next;
  logic                   rd_hi_reg, rd_hi_next;
  logic                   rd_mask_reg, rd_mask_next;
  logic                   req_next;
  isp_pkg::mem_cmd_t      cmd_next;
  logic [14:0]            addr_next;
  logic [15:0]            wdata_next;
  logic                   hold_next, busy_next;
  logic                   rd_go, ok_cmd;
  logic [14:0]            rd_addr;

  // A read is issued as soon as its third byte is in
  assign rd_go = en_reg & sif.byte_tick & (sif.bit_cnt == `ISP_READ_BIT)
               & (((p1 & `ISP_H_MASK) == `ISP_READ_PROG)
                  | (p1 == `ISP_READ_EE));
  assign rd_addr = ((p1 & `ISP_H_MASK) == `ISP_READ_PROG) ?
                   {p2[6:0], p3} : {4'h0, p2[2:0], p3};
  // refuse until enabled
  // Writes are also refused while a self-timed write is still running
  assign ok_cmd = en_reg & sif.frame_tick & (st_reg == isp_pkg::PG_IDLE);

  always_comb begin
    st_next       = st_reg;
    kind_next     = kind_reg;
    en_next       = en_reg;
    wait_next     = wait_reg;
    idx_next      = idx_reg;
    page_next     = page_reg;
    ee_addr_next  = ee_addr_reg;
    buf_next      = buf_reg;
    rd_pend_next  = rd_pend_reg;
    rd_flash_next = rd_flash_reg;
    rd_hi_next    = rd_hi_reg;
    rd_mask_next  = rd_mask_reg;
    req_next      = 1'b0;
    cmd_next      = mem_cmd;
    addr_next     = mem_addr;
    wdata_next    = mem_wdata;
    hold_next     = session;

    // Reply data belongs to one frame only
    if (sif.frame_tick || !session) begin
      rd_pend_next = 1'b0;
    end

    if (!session) begin
      en_next = 1'b0;
    end else if (sif.frame_tick && b1 == `ISP_PROG_EN
                 && b2 == `ISP_ECHO_BYTE) begin
      en_next = 1'b1;
    end

    if (rd_go) begin
      req_next      = 1'b1;
      cmd_next      = ((p1 & `ISP_H_MASK) == `ISP_READ_PROG) ?
                      isp_pkg::MEM_RD_FLASH : isp_pkg::MEM_RD_EE;
      addr_next     = rd_addr;
      rd_pend_next  = 1'b1;
      rd_flash_next = ((p1 & `ISP_H_MASK) == `ISP_READ_PROG);
      rd_hi_next    = p1[`ISP_H_BIT];
      rd_mask_next  = (st_reg != isp_pkg::PG_IDLE)
                    && ((kind_reg == isp_pkg::BUSY_ERASE)
                        || (kind_reg == isp_pkg::BUSY_FLASH
                            && ((p1 & `ISP_H_MASK) == `ISP_READ_PROG)
                            && rd_addr[14:7] == page_reg)
                        || (kind_reg == isp_pkg::BUSY_EE
                            && p1 == `ISP_READ_EE
                            && rd_addr[10:0] == ee_addr_reg));
    end

    case (st_reg)
      isp_pkg::PG_IDLE: begin
        if (ok_cmd) begin
          if ((b1 & `ISP_H_MASK) == `ISP_LOAD_PAGE) begin
            if (b1[`ISP_H_BIT]) begin
              buf_next[b3[6:0]][15:8] = b4;
            end else begin
              buf_next[b3[6:0]][7:0] = b4;
            end
          end else if (b1 == `ISP_WRITE_PAGE) begin
            page_next = {b2[6:0], b3[7]};
            idx_next  = 7'h00;
            kind_next = isp_pkg::BUSY_FLASH;
            st_next   = isp_pkg::PG_STREAM;
          end else if (b1 == `ISP_WRITE_EE) begin
            req_next     = 1'b1;
            cmd_next     = isp_pkg::MEM_WR_EE;
            addr_next    = {4'h0, b2[2:0], b3};
            wdata_next   = {8'h00, b4};
            ee_addr_next = {b2[2:0], b3};
            kind_next    = isp_pkg::BUSY_EE;
            wait_next    = `ISP_WAIT_W'(EE_WAIT_CYC - 1);
            st_next      = isp_pkg::PG_WAIT;
          end else if (b1 == `ISP_PROG_EN && b2[7:5] == `ISP_ERASE_SEL) begin
            req_next  = 1'b1;
            cmd_next  = isp_pkg::MEM_ERASE;
            addr_next = 15'h0000;
            kind_next = isp_pkg::BUSY_ERASE;
            wait_next = `ISP_WAIT_W'(EE_WAIT_CYC - 1);
            st_next   = isp_pkg::PG_WAIT;
            for (int i = 0; i < `ISP_PAGE_WORDS; i++) begin
              buf_next[i] = `ISP_ERASED_WORD;
            end
          end
        end
      end
      isp_pkg::PG_STREAM: begin
        // One word per cycle; a polling read takes the slot first
        if (!rd_go) begin
          req_next          = 1'b1;
          cmd_next          = isp_pkg::MEM_WR_FLASH;
          addr_next         = {page_reg, idx_reg};
          wdata_next        = buf_reg[idx_reg];
          buf_next[idx_reg] = `ISP_ERASED_WORD;
          idx_next          = idx_reg + 7'h01;
          if (idx_reg == `ISP_LAST_WORD) begin
            wait_next = `ISP_WAIT_W'(FLASH_WAIT_CYC - 1);
            st_next   = isp_pkg::PG_WAIT;
          end
        end
      end
      isp_pkg::PG_WAIT: begin
        if (wait_reg == '0) begin
          st_next = isp_pkg::PG_IDLE;
        end else begin
          wait_next = wait_reg - `ISP_WAIT_W'(1);
        end
      end
      default: begin
        st_next = isp_pkg::PG_IDLE;
      end
    endcase
    busy_next = (st_next != isp_pkg::PG_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_reg       <= isp_pkg::PG_IDLE;
      kind_reg     <= isp_pkg::BUSY_FLASH;
      en_reg       <= 1'b0;
      wait_reg     <= '0;
      idx_reg      <= 7'h00;
      page_reg     <= 8'h00;
      ee_addr_reg  <= 11'h000;
      rd_pend_reg  <= 1'b0;
      rd_flash_reg <= 1'b0;
      rd_hi_reg    <= 1'b0;
      rd_mask_reg  <= 1'b0;
      mem_req      <= 1'b0;
      mem_cmd      <= isp_pkg::MEM_NONE;
      mem_addr     <= 15'h0000;
      mem_wdata    <= 16'h0000;
      hold_cpu     <= 1'b0;
      busy         <= 1'b0;
      for (int i = 0; i < `ISP_PAGE_WORDS; i++) begin
        buf_reg[i] <= `ISP_ERASED_WORD;
      end
    end else begin
      st_reg       <= st_next;
      kind_reg     <= kind_next;
      en_reg       <= en_next;
      wait_reg     <= wait_next;
      idx_reg      <= idx_next;
      page_reg     <= page_next;
      ee_addr_reg  <= ee_addr_next;
      rd_pend_reg  <= rd_pend_next;
      rd_flash_reg <= rd_flash_next;
      rd_hi_reg    <= rd_hi_next;
      rd_mask_reg  <= rd_mask_next;
      mem_req      <= req_next;
      mem_cmd      <= cmd_next;
      mem_addr     <= addr_next;
      mem_wdata    <= wdata_next;
      hold_cpu     <= hold_next;
      busy         <= busy_next;
      buf_reg      <= buf_next;
    end
  end

  // Reply byte: read data in byte four, else the last byte received.
  // The array must hold its read data until the next request.
  always_comb begin
    sif.reply = sif.rx_word[7:0];
    if (rd_pend_reg && sif.bit_cnt == `ISP_READ_BIT) begin
      if (rd_mask_reg) begin
        sif.reply = `ISP_ERASED_BYTE;
      end else if (rd_flash_reg && rd_hi_reg) begin
        sif.reply = mem_rdata[15:8];
      end else begin
        sif.reply = mem_rdata[7:0];
      end
    end
  end

  assign sdo = sif.sdo;
endmodule // isp_port

// >>> isp_port_chk.sv
module isp_port_chk #(
  parameter int unsigned FLASH_WAIT_CYC = 200,
  parameter int unsigned EE_WAIT_CYC    = 400
) (
  input wire logic              clk,              // Core clock
  input wire logic              rstn,             // Power-on reset
  input wire logic              reset_pin_n,      // Device reset pin
  input wire logic              prog_entry_pin_n, // Entry pin
  input wire logic              sck,              // Serial clock
  input wire logic              sdi,              // Serial data in
  input wire logic              sdo,              // Serial data out
  input wire logic              hold_cpu,         // Session active
  input wire logic              busy,             // Write running
  input wire logic              mem_req,          // Array request
  input wire isp_pkg::mem_cmd_t mem_cmd,          // Array operation
  input wire logic       [14:0] mem_addr,         // Array address
  input wire logic       [15:0] mem_wdata,        // Write data
  input wire logic       [15:0] mem_rdata         // Read data
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [31:0]       cnt_reg, cnt_next;
  isp_pkg::mem_cmd_t kind_reg, kind_next;
  logic              wr;

  // Any request that changes the array
  assign wr = mem_req && mem_cmd inside {isp_pkg::MEM_WR_FLASH,
              isp_pkg::MEM_WR_EE, isp_pkg::MEM_ERASE};

  // Length of each busy stretch and the last write request seen
  always_comb begin
    cnt_next  = busy ? cnt_reg + 32'h1 : 32'h0;
    // Page writes raise busy a cycle before their first request
    kind_next = wr ? mem_cmd : kind_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg    <= 32'h0;
      kind_reg   <= isp_pkg::MEM_NONE;
    end else begin
      cnt_reg    <= cnt_next;
      kind_reg   <= kind_next;
    end
  end

  AST_SDO_FALL: assert property ($changed(sdo) |-> !sck)
    else $error("sdo moved while serial clock high");
  AST_WR_SESSION: assert property (wr |-> hold_cpu)
    else $error("array write outside a session");
  AST_BUSY_START: assert property ($rose(busy) |-> ##[0:1] wr)
    else $error("busy rose without a write request");
  AST_PAGE_STREAM: assert property (
    mem_req && mem_cmd == isp_pkg::MEM_WR_FLASH && mem_addr[6:0] != 7'h7f
    |=> mem_req && mem_cmd == isp_pkg::MEM_WR_FLASH
        && mem_addr == $past(mem_addr) + 15'h1)
    else $error("page stream broke off");
  AST_FLASH_WAIT: assert property (
    $fell(busy) && kind_reg == isp_pkg::MEM_WR_FLASH
    |-> cnt_reg >= FLASH_WAIT_CYC + 128 && cnt_reg <= FLASH_WAIT_CYC + 132)
    else $error("page write busy length off");
  AST_EE_WAIT: assert property (
    $fell(busy) && kind_reg != isp_pkg::MEM_WR_FLASH
    |-> cnt_reg >= EE_WAIT_CYC && cnt_reg <= EE_WAIT_CYC + 4)
    else $error("byte write or erase busy length off");
  AST_EE_FORMAT: assert property (
    mem_req && mem_cmd == isp_pkg::MEM_WR_EE
    |-> mem_wdata[15:8] == 8'h00 && mem_addr[14:11] == 4'h0)
    else $error("byte write request malformed");
  AST_SESSION: assert property (!reset_pin_n [*8] |=> hold_cpu)
    else $error("no session while reset pin low");
  AST_END_CAUSE: assert property (
    $fell(hold_cpu) |-> $past(reset_pin_n, 2))
    else $error("session ended with reset pin low");

  // Main scenarios
  cover property ($fell(busy) && kind_reg == isp_pkg::MEM_WR_FLASH);
  cover property (mem_req && mem_cmd == isp_pkg::MEM_ERASE);
  cover property ($fell(hold_cpu));
endmodule // isp_port_chk

bind isp_port isp_port_chk #(
  .FLASH_WAIT_CYC(FLASH_WAIT_CYC),
  .EE_WAIT_CYC   (EE_WAIT_CYC)
) i_chk (
  .clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
  .prog_entry_pin_n(prog_entry_pin_n), .sck(sck), .sdi(sdi), .sdo(sdo),
  .hold_cpu(hold_cpu), .busy(busy), .mem_req(mem_req),
  .mem_cmd(mem_cmd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata)
);

// >>> isp_programmer.sv
module isp_programmer (
  input  wire logic clk, // Core clock, paces the serial clock
  input  wire logic sdo, // Serial data from the device
  output logic      sck, // Serial clock, idles low
  output logic      sdi  // Serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck = 1'b0;
    sdi = 1'b0;
  end

  // One whole frame; half is the phase length in core cycles
  // four bytes, msb first, long phases
  task automatic xfer(input logic [31:0] f, input int half,
                      output logic [31:0] r);
    for (int i = 31; i >= 0; i--) begin
      sdi <= f[i];
      repeat (half) @(posedge clk);
      sck <= 1'b1;
      r[i] = sdo;
      repeat (half) @(posedge clk);
      sck <= 1'b0;
    end
    // Released line shows the inverse; the wait keeps the next frame's
    // first bit out of this time step
    sdi <= ~f[0];
    repeat (half) @(posedge clk);
  endtask
endmodule // isp_programmer

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned FW = 300;
  localparam int unsigned EW = 600;

  logic              clk, rstn, reset_pin_n, prog_entry_pin_n;
  logic              sck, sdi, sdo, hold_cpu, busy, mem_req;
  isp_pkg::mem_cmd_t mem_cmd;
  logic [14:0]       mem_addr;
  logic [15:0]       mem_wdata, mem_rdata;
  logic [15:0]       fl [logic [14:0]];
  logic [7:0]        ee [logic [14:0]];
  int                failures, comparisons, wr_reqs, cycles;

  isp_port #(.FLASH_WAIT_CYC(FW), .EE_WAIT_CYC(EW)) i_dut (
    .clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .prog_entry_pin_n(prog_entry_pin_n), .sck(sck), .sdi(sdi), .sdo(sdo),
    .hold_cpu(hold_cpu), .busy(busy), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  isp_programmer i_prog (.clk(clk), .sdo(sdo), .sck(sck), .sdi(sdi));

  // Core clock, 8 ns period
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Array model: read data lands the cycle after the request
  always @(posedge clk) begin
    if (mem_req) begin
      case (mem_cmd)
        isp_pkg::MEM_WR_FLASH: fl[mem_addr] = mem_wdata;
        isp_pkg::MEM_WR_EE: ee[mem_addr] = mem_wdata[7:0];
        isp_pkg::MEM_ERASE: begin
          fl.delete();
          ee.delete();
        end
        isp_pkg::MEM_RD_FLASH:
          mem_rdata <= fl.exists(mem_addr) ? fl[mem_addr] : 16'hffff;
        isp_pkg::MEM_RD_EE:
          mem_rdata <= {8'h00, ee.exists(mem_addr) ? ee[mem_addr] : 8'hff};
        default: ;
      endcase
      if (mem_cmd inside {isp_pkg::MEM_WR_EE, isp_pkg::MEM_ERASE}) wr_reqs++;
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("timeout after %0d cycles", cycles);
      results;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [31:0] f, output logic [31:0] r);
    i_prog.xfer(f, 10, r);
  endtask

  // poll busy, not data, so 0xff pages wait in full
  task automatic wait_idle;
    for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clk);
    check({15'h0, busy}, 16'h0);
  endtask

  task automatic t_refuse;
    logic [31:0] r;
    int          n;
    // settle wait shortened; the core does not time it
    repeat (40) @(posedge clk);
    check({15'h0, hold_cpu}, 16'h1);
    n = wr_reqs;
    frame(32'hc0_01_23_5a, r);
    repeat (20) @(posedge clk);
    check(16'(wr_reqs - n), 16'h0);
    $display("t_refuse done");
  endtask

  task automatic t_enable;
    logic [31:0] r;
    frame(32'hac_53_00_00, r);
    // lost echo: pulse reset high, then enable again
    if (r[15:8] !== 8'h53) begin
      reset_pin_n <= 1'b1;
      repeat (20) @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (40) @(posedge clk);
      frame(32'hac_53_00_00, r);
    end
    check({8'h00, r[15:8]}, 16'h0053);
    $display("t_enable done");
  endtask

  task automatic t_ee;
    logic [31:0] r;
    frame(32'hc0_01_23_5a, r);
    i_prog.xfer(32'ha0_01_23_00, 5, r);
    check({8'h00, r[7:0]}, 16'h00ff);
    wait_idle;
    frame(32'ha0_01_23_00, r);
    check({8'h00, r[7:0]}, 16'h005a);
    $display("t_ee done");
  endtask

  task automatic t_page;
    logic [31:0] r;
    frame(32'h40_00_05_34, r);
    frame(32'h48_00_05_12, r);
    frame(32'h4c_03_80_00, r);
    i_prog.xfer(32'h20_03_86_00, 5, r);
    check({8'h00, r[7:0]}, 16'h00ff);
    wait_idle;
    frame(32'h20_03_85_00, r);
    check({8'h00, r[7:0]}, 16'h0034);
    frame(32'h28_03_85_00, r);
    check({8'h00, r[7:0]}, 16'h0012);
    $display("t_page done");
  endtask

  task automatic t_erase;
    logic [31:0] r;
    frame(32'hac_80_00_00, r);
    wait_idle;
    frame(32'h28_03_85_00, r);
    check({8'h00, r[7:0]}, 16'h00ff);
    frame(32'ha0_01_23_00, r);
    check({8'h00, r[7:0]}, 16'h00ff);
    $display("t_erase done");
  endtask

  task automatic t_end;
    logic [31:0] r;
    int          n;
    reset_pin_n <= 1'b1;
    repeat (20) @(posedge clk);
    check({15'h0, hold_cpu}, 16'h0);
    reset_pin_n <= 1'b0;
    repeat (40) @(posedge clk);
    n = wr_reqs;
    frame(32'hc0_00_10_77, r);
    repeat (20) @(posedge clk);
    check(16'(wr_reqs - n), 16'h0);
    $display("t_end done");
  endtask

  task automatic t_pin;
    logic [31:0] r;
    reset_pin_n <= 1'b1;
    prog_entry_pin_n <= 1'b0;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    prog_entry_pin_n <= 1'b1;
    repeat (40) @(posedge clk);
    check({15'h0, hold_cpu}, 16'h1);
    frame(32'hac_53_00_00, r);
    check({8'h00, r[15:8]}, 16'h0053);
    $display("t_pin done");
  endtask

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence; reset pin low from power-up opens a session
  initial begin
    rstn = 1'b0;
    reset_pin_n = 1'b0;
    prog_entry_pin_n = 1'b1;
    failures = 0;
    comparisons = 0;
    wr_reqs = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_refuse;
    t_enable;
    t_ee;
    t_page;
    t_erase;
    t_end;
    t_pin;
    results;
  end
endmodule // tb
